/* File: pcfg_pkg.sv */
// How it works
// - Two 8-bit read/write configuration registers at their indices, both reset to 00.
// - Low-bit register takes 8- or 16-bit accesses; high-bit register is 8-bit only.
// - Pin n setting is high-register bit n over low-register bit n.
// - Direction bit 0 selects the output-drive meaning, 1 the input-termination meaning.
// - Output mode setting 00 keeps the driver in high impedance, the reset state.
// - Output setting 01 drives high for data 1, floats for data 0.
// - Output setting 10 drives low for data 0, floats for data 1.
// - Output setting 11 drives push-pull with the data bit.
// - Input setting 00 or 11 gives a plain high-impedance input, no pull.
// - Input setting 01 turns on the pull-down.
// - Input setting 10 turns on the pull-up.
// - Reset clears all direction bits, so pins start as high-impedance outputs.
// - Output mode data reads return the data register bit; input mode data reads return sampled pins.
package pcfg_pkg;

  // ****************************************
  // Register map (index, byte address is four times it)
  // ****************************************
  localparam logic [15:0] PCFG_IDX_DATA   = 16'hF268;
  localparam logic [15:0] PCFG_IDX_DIR    = 16'hF269;
  localparam logic [15:0] PCFG_IDX_CFG_LO = 16'hF26A;
  localparam logic [15:0] PCFG_IDX_CFG_HI = 16'hF26B;

  localparam int          PCFG_AW         = 20;
  localparam int          PCFG_PINS       = 8;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0]  PCFG_RST_DATA   = 8'h00;
  localparam logic [7:0]  PCFG_RST_DIR    = 8'h00;
  localparam logic [7:0]  PCFG_RST_CFG    = 8'h00;

  // ****************************************
  // Field positions and encodings
  // ****************************************
  localparam int          PCFG_LANE0_LSB  = 0;
  localparam int          PCFG_LANE1_LSB  = 8;
  localparam logic        PCFG_DIR_OUT    = 1'b0;
  localparam logic [1:0]  PCFG_SET_HIZ    = 2'h0;
  localparam logic [1:0]  PCFG_SET_PCH    = 2'h1;
  localparam logic [1:0]  PCFG_SET_NCH    = 2'h2;
  localparam logic [1:0]  PCFG_SET_CMOS   = 2'h3;

  typedef enum logic [2:0] {
    PCFG_IDLE   = 3'h1,
    PCFG_SETUP  = 3'h2,
    PCFG_ACCESS = 3'h4
  } pcfg_phase_e;

  typedef struct packed {
    logic out;
    logic oe_n;
    logic pull_up;
    logic pull_down;
  } pcfg_pad_s;

  function automatic logic [PCFG_AW-1:0] pcfg_byte_addr(input logic [15:0] idx);
    pcfg_byte_addr = {2'b00, idx, 2'b00};
  endfunction

  // Decode one pin: direction, 2-bit setting, data bit
  function automatic pcfg_pad_s pcfg_pad(input logic dir, input logic [1:0] set, input logic dat);
    pcfg_pad_s p;
    p = '{out: 1'b0, oe_n: 1'b1, pull_up: 1'b0, pull_down: 1'b0};
    if (dir == PCFG_DIR_OUT) begin
      case (set)
        PCFG_SET_PCH: begin
          p.out  = 1'b1;
          p.oe_n = ~dat;
        end
        PCFG_SET_NCH: begin
          p.out  = 1'b0;
          p.oe_n = dat;
        end
        PCFG_SET_CMOS: begin
          p.out  = dat;
          p.oe_n = 1'b0;
        end
        default: p.oe_n = 1'b1;
      endcase
    end else begin
      p.pull_down = (set == PCFG_SET_PCH);
      p.pull_up   = (set == PCFG_SET_NCH);
      // settings 00 and 11 leave no pull
    end
    return p;
  endfunction

endpackage

/* File: pcfg_apb_dec.sv */
`timescale 1ns/1ps
module pcfg_apb_dec
  import pcfg_pkg::*;
(
  // Request
  input  wire logic [PCFG_AW-1:0] paddr,
  // Decoded selects
  output logic                    hit_data,
  output logic                    hit_dir,
  output logic                    hit_lo,
  output logic                    hit_hi,
  output logic                    miss
);

  // ****************************************
  // Address decode
  // ****************************************
  always_comb begin
    hit_data = (paddr == pcfg_byte_addr(PCFG_IDX_DATA));
    hit_dir  = (paddr == pcfg_byte_addr(PCFG_IDX_DIR));
    hit_lo   = (paddr == pcfg_byte_addr(PCFG_IDX_CFG_LO));
    hit_hi   = (paddr == pcfg_byte_addr(PCFG_IDX_CFG_HI));
    miss     = ~(hit_data | hit_dir | hit_lo | hit_hi);
  end

endmodule

/* File: pcfg_pad_ctl.sv */
`timescale 1ns/1ps
module pcfg_pad_ctl
  import pcfg_pkg::*;
(
  // Register state
  input  wire logic [7:0] data,
  input  wire logic [7:0] dir,
  input  wire logic [7:0] cfg_lo,
  input  wire logic [7:0] cfg_hi,
  // Pad controls
  output logic      [7:0] pad_out,
  output logic      [7:0] pad_oe_n,
  output logic      [7:0] pad_pu,
  output logic      [7:0] pad_pd
);

  // ****************************************
  // Per-pin decode
  // ****************************************
  always_comb begin
    pcfg_pad_s p;
    p = '0;
    for (int n = 0; n < PCFG_PINS; n++) begin
      // setting = high bit over low bit
      p           = pcfg_pad(dir[n], {cfg_hi[n], cfg_lo[n]}, data[n]);
      pad_out[n]  = p.out;
      pad_oe_n[n] = p.oe_n;
      pad_pu[n]   = p.pull_up;
      pad_pd[n]   = p.pull_down;
    end
  end

endmodule

/* File: pcfg_port.sv */
`timescale 1ns/1ps
module pcfg_port
  import pcfg_pkg::*;
(
  // Clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // APB slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [PCFG_AW-1:0] paddr,
  input  wire logic [31:0]        pwdata,
  input  wire logic [3:0]         pstrb,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Port pins
  input  wire logic [7:0]         pin_in,
  output logic      [7:0]         pin_out,
  output logic      [7:0]         pin_oe_n,
  output logic      [7:0]         pin_pull_up,
  output logic      [7:0]         pin_pull_down
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    pcfg_phase_e phase;
    logic [7:0]  pin_data_reg;
    logic [7:0]  pin_direction_reg;
    logic [7:0]  pin_cfg_low_bits;
    logic [7:0]  pin_cfg_high_bits;
    logic [7:0]  pin_smp;
    logic [31:0] rdata;
    logic        err;
    logic [7:0]  out;
    logic [7:0]  oe_n;
    logic [7:0]  pu;
    logic [7:0]  pd;
  } pcfg_state_s;

  // Reset image: data 0, all outputs, all settings high impedance
  localparam pcfg_state_s PCFG_STATE_RST = '{
    phase:             PCFG_IDLE,
    pin_data_reg:      PCFG_RST_DATA,
    pin_direction_reg: PCFG_RST_DIR,
    pin_cfg_low_bits:  PCFG_RST_CFG,
    pin_cfg_high_bits: PCFG_RST_CFG,
    pin_smp:           8'h00,
    rdata:             32'h0000_0000,
    err:               1'b0,
    out:               8'h00,
    oe_n:              8'hFF,
    pu:                8'h00,
    pd:                8'h00
  };

  pcfg_state_s st;
  pcfg_state_s next_st;

  // ****************************************
  // Decode and pad control
  // ****************************************
  logic       hit_data;
  logic       hit_dir;
  logic       hit_lo;
  logic       hit_hi;
  logic       miss;
  logic [7:0] pad_out;
  logic [7:0] pad_oe_n;
  logic [7:0] pad_pu;
  logic [7:0] pad_pd;
  logic [7:0] rd_port;
  logic       setup_ph;
  logic       wr_take;
  logic       acc_ph;
  logic       wr_lane0;
  logic       wr_lane1;
  logic [7:0] next_data;
  logic [7:0] next_dir;
  logic [7:0] next_lo;
  logic [7:0] next_hi;

  logic [31:0] rd_view;

  pcfg_apb_dec u_dec (
    .paddr    (paddr),
    .hit_data (hit_data),
    .hit_dir  (hit_dir),
    .hit_lo   (hit_lo),
    .hit_hi   (hit_hi),
    .miss     (miss)
  );

  // Pads follow the next register values so a write reaches the pins at the same edge at which it is taken
  // Fed from plain nets, not from next_st, so the pad decode never loops back into the state process
  pcfg_pad_ctl u_pad (
    .data     (next_data),
    .dir      (next_dir),
    .cfg_lo   (next_lo),
    .cfg_hi   (next_hi),
    .pad_out  (pad_out),
    .pad_oe_n (pad_oe_n),
    .pad_pu   (pad_pu),
    .pad_pd   (pad_pd)
  );

  // ****************************************
  // Bus phases
  // ****************************************
  assign setup_ph = psel & ~penable;
  assign acc_ph   = psel & penable;
  // Write lands only at the completing edge of the access phase
  assign wr_take  = acc_ph & pready & pwrite & ~st.err;

  // ****************************************
  // Register helpers
  // ****************************************
  // Keep a byte register or load it from a write lane
  function automatic logic [7:0] pick_byte(
    input logic [7:0] cur,
    input logic       wen,
    input logic [7:0] val
  );
    pick_byte = wen ? val : cur;
  endfunction

  // Input bits show the sampled pin, output bits the register
  function automatic logic [7:0] port_view(
    input logic [7:0] dat,
    input logic [7:0] dir,
    input logic [7:0] smp
  );
    port_view = (dat & ~dir) | (smp & dir);
  endfunction

  // Read image of one register; anything not selected reads as zero
  function automatic logic [31:0] read_view(
    input logic [3:0] sel,
    input logic [7:0] port_v,
    input logic [7:0] dir_v,
    input logic [7:0] lo_v,
    input logic [7:0] hi_v
  );
    logic [31:0] w;
    w = 32'h0000_0000;
    case (sel)
      // Data register: sampled pins for inputs
      4'h1: begin
        w[7:0] = port_v;
      end
      4'h2: begin
        w[7:0] = dir_v;
      end
      // word view at the low-bit register
      4'h4: begin
        w[15:0] = {hi_v, lo_v};
      end
      4'h8: begin
        w[7:0] = hi_v;
      end
      default: begin
        w = 32'h0000_0000;
      end
    endcase
    return w;
  endfunction

  // input bits read the pin, output bits read the register
  assign rd_port   = port_view(st.pin_data_reg, st.pin_direction_reg, st.pin_smp);
  // Selects are one-hot, so the case in read_view never sees two hits
  assign rd_view   = read_view({hit_hi, hit_lo, hit_dir, hit_data}, rd_port, st.pin_direction_reg,
                               st.pin_cfg_low_bits, st.pin_cfg_high_bits);

  // ****************************************
  // Next register values
  // ****************************************
  // Lane 0 reaches every byte register; lane 1 only the upper half of the word view
  assign wr_lane0  = wr_take & pstrb[0];
  // upper lane of a word write
  assign wr_lane1  = wr_take & pstrb[1] & hit_lo;
  assign next_data = pick_byte(st.pin_data_reg, wr_lane0 & hit_data, pwdata[PCFG_LANE0_LSB +: 8]);
  assign next_dir  = pick_byte(st.pin_direction_reg, wr_lane0 & hit_dir, pwdata[PCFG_LANE0_LSB +: 8]);
  assign next_lo   = pick_byte(st.pin_cfg_low_bits, wr_lane0 & hit_lo, pwdata[PCFG_LANE0_LSB +: 8]);
  // high-bit register takes lane 0 only; a word write at the low-bit address fills it from lane 1
  assign next_hi   = wr_lane1 ? pwdata[PCFG_LANE1_LSB +: 8] :
                     pick_byte(st.pin_cfg_high_bits, wr_lane0 & hit_hi, pwdata[PCFG_LANE0_LSB +: 8]);

  always_comb begin
    next_st = st;

    // ****************************************
    // Phase tracking
    // ****************************************
    case (st.phase)
      PCFG_IDLE: begin
        if (setup_ph) begin
          next_st.phase = PCFG_SETUP;
        end
      end
      PCFG_SETUP: begin
        // One wait state: the answer comes in the second cycle of the access phase
        // A dropped select abandons the transfer rather than answer a bus that moved on
        if (acc_ph) begin
          next_st.phase = PCFG_ACCESS;
        end else begin
          next_st.phase = PCFG_IDLE;
        end
      end
      PCFG_ACCESS: begin
        // Back-to-back setup is allowed right after completion
        if (setup_ph) begin
          next_st.phase = PCFG_SETUP;
        end else begin
          next_st.phase = PCFG_IDLE;
        end
      end
      default: begin
        next_st.phase = PCFG_IDLE;
      end
    endcase

    // ****************************************
    // Pin sampling
    // ****************************************
    // Pins are synchronous to pclk; one flop keeps reads stable across the access
    next_st.pin_smp = pin_in;

    // ****************************************
    // Read data and error, captured at setup
    // ****************************************
    if (setup_ph) begin
      next_st.err = miss;
      // A write returns zero, so no stale word stands in its access phase
      if (pwrite) begin
        next_st.rdata = 32'h0000_0000;
      end else begin
        next_st.rdata = rd_view;
      end
    end

    // ****************************************
    // Register writes
    // ****************************************
    next_st.pin_data_reg      = next_data;
    next_st.pin_direction_reg = next_dir;
    next_st.pin_cfg_low_bits  = next_lo;
    next_st.pin_cfg_high_bits = next_hi;

    // ****************************************
    // Pad outputs
    // ****************************************
    // output level from data register
    next_st.out  = pad_out;
    next_st.oe_n = pad_oe_n;
    next_st.pu   = pad_pu;
    next_st.pd   = pad_pd;
  end

  // ****************************************
  // State register
  // ****************************************
  // reset clears direction and settings
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= PCFG_STATE_RST;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign pready        = (st.phase == PCFG_ACCESS);
  assign prdata        = st.rdata;
  // Error shows only with the answer, never in the wait cycle
  assign pslverr       = pready & st.err;
  assign pin_out       = st.out;
  assign pin_oe_n      = st.oe_n;
  assign pin_pull_up   = st.pu;
  assign pin_pull_down = st.pd;

endmodule

/* File: pcfg_port_checker.sv */
`timescale 1ns/1ps
module pcfg_port_checker
  import pcfg_pkg::*;
(
  // Clock and reset
  input wire logic               pclk,
  input wire logic               presetn,
  // APB slave
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [PCFG_AW-1:0] paddr,
  input wire logic [31:0]        pwdata,
  input wire logic [3:0]         pstrb,
  input wire logic [31:0]        prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  // Port pins
  input wire logic [7:0]         pin_in,
  input wire logic [7:0]         pin_out,
  input wire logic [7:0]         pin_oe_n,
  input wire logic [7:0]         pin_pull_up,
  input wire logic [7:0]         pin_pull_down
);
  // ****************************************
  // Properties
  // ****************************************
  logic setup;
  logic mapped;
  assign setup  = psel && !penable;
  assign mapped = paddr inside {{2'b00, PCFG_IDX_DATA, 2'b00}, {2'b00, PCFG_IDX_DIR, 2'b00},
                                {2'b00, PCFG_IDX_CFG_LO, 2'b00}, {2'b00, PCFG_IDX_CFG_HI, 2'b00}};
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rdy; setup |=> !pready ##1 pready; endproperty
  a_rdy: assert property (p_rdy) else $error("pready missing after setup");
  property p_no_rdy; pready |-> $past(setup, 2); endproperty
  a_no_rdy: assert property (p_no_rdy) else $error("pready without setup");
  property p_err; setup && !mapped |=> ##1 pslverr && prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("unmapped access not refused");
  property p_ok; setup && mapped |=> ##1 pready && !pslverr; endproperty
  a_ok: assert property (p_ok) else $error("mapped access refused");
  property p_excl; (pin_pull_up & pin_pull_down) == 8'h00; endproperty
  a_excl: assert property (p_excl) else $error("both pulls on");
  property p_nodrv; ((pin_pull_up | pin_pull_down) & ~pin_oe_n) == 8'h00; endproperty
  a_nodrv: assert property (p_nodrv) else $error("pull on a driven pin");
  property p_rst; $rose(presetn) |-> pin_oe_n == 8'hFF && (pin_pull_up | pin_pull_down) == 8'h00; endproperty
  a_rst: assert property (p_rst) else $error("pins not idle after reset");
  property p_cause;
    !$stable({pin_out, pin_oe_n, pin_pull_up, pin_pull_down}) |-> $past(psel && penable && pwrite);
  endproperty
  a_cause: assert property (p_cause) else $error("pins changed without a write");
  c_err: cover property (setup && !mapped);
  c_pu: cover property (pin_pull_up != 8'h00);
  c_drv: cover property (pin_oe_n != 8'hFF);
endmodule

bind pcfg_port pcfg_port_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
  .pin_pull_up(pin_pull_up), .pin_pull_down(pin_pull_down));

/* File: tb_top.sv */
`timescale 1ns/1ps
module tb_top
  import pcfg_pkg::*;
;
  localparam logic [19:0] A_DAT = {2'b00, PCFG_IDX_DATA, 2'b00};
  localparam logic [19:0] A_DIR = {2'b00, PCFG_IDX_DIR, 2'b00};
  localparam logic [19:0] A_LO  = {2'b00, PCFG_IDX_CFG_LO, 2'b00};
  localparam logic [19:0] A_HI  = {2'b00, PCFG_IDX_CFG_HI, 2'b00};
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [19:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [7:0]  pin_in, pin_out, pin_oe_n, pin_pull_up, pin_pull_down, l, h;
  int          errors, cmp_count, cyc;

  pcfg_port DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pull_up(pin_pull_up),
    .pin_pull_down(pin_pull_down));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Request holds from just after one edge to the edge at which pready is seen high;
  // the idle edge between calls keeps a strobe from being driven twice in one step
  task automatic xfer(input logic w, input logic [19:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdx(input string nm, input logic [19:0] a, input logic [31:0] e, input logic ee);
    xfer(1'b0, a, 32'h0, 4'h0);
    chk(nm, e, rd);
    chk("pslverr", {31'h0, ee}, {31'h0, er});
  endtask

  // Only driven bits of pin_out carry meaning
  function automatic logic [31:0] pads(input logic [7:0] d, r, lo, hi);
    logic [7:0] oe;
    oe = r | ~(lo | hi) | (~hi & lo & ~d) | (hi & ~lo & d);
    return {~oe & ((lo & ~hi) | (hi & lo & d)), oe, r & hi & ~lo, r & lo & ~hi};
  endfunction

  task automatic pins(input logic [7:0] d, r, lo, hi);
    @(posedge pclk);
    @(negedge pclk);
    chk("pins", pads(d, r, lo, hi), {pin_out & ~pin_oe_n, pin_oe_n, pin_pull_up, pin_pull_down});
  endtask

  // ****************************************
  // Stimulus
  // ****************************************
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc++;
    if (cyc > 3000) begin
      errors++;
      summarize();
    end
  end

  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 20'h0;
    pwdata  = 32'h0;
    pstrb   = 4'h0;
    pin_in  = 8'h9C;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rdx("data", A_DAT, 32'h0, 1'b0);
    rdx("dir", A_DIR, 32'h0, 1'b0);
    rdx("lo", A_LO, 32'h0, 1'b0);
    rdx("hi", A_HI, 32'h0, 1'b0);
    pins(8'h00, 8'h00, 8'h00, 8'h00);
    $display("test reset done");
    xfer(1'b1, A_DAT, 32'h05, 4'h1);
    xfer(1'b1, A_DIR, 32'hF0, 4'h1);
    for (int s = 0; s < 4; s++) begin
      l = {8{s[0]}};
      h = {8{s[1]}};
      xfer(1'b1, A_LO, {24'h0, l}, 4'h1);
      xfer(1'b1, A_HI, {24'h0, h}, 4'h1);
      pins(8'h05, 8'hF0, l, h);
    end
    rdx("input", A_DAT, 32'h95, 1'b0);
    $display("test modes done");
    xfer(1'b1, A_LO, 32'h3CC3, 4'h3);
    rdx("word", A_LO, 32'h3CC3, 1'b0);
    rdx("hi", A_HI, 32'h3C, 1'b0);
    xfer(1'b1, A_LO, 32'hFF11, 4'h1);
    xfer(1'b1, A_HI, 32'hAB55, 4'h3);
    rdx("lo", A_LO, 32'h5511, 1'b0);
    pins(8'h05, 8'hF0, 8'h11, 8'h55);
    $display("test word done");
    rdx("unmapped", 20'h3C9B0, 32'h0, 1'b1);
    xfer(1'b1, 20'h3C9A9, 32'hFF, 4'h1);
    chk("slverr", 32'h1, {31'h0, er});
    rdx("lo", A_LO, 32'h5511, 1'b0);
    $display("test refused done");
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    rdx("lo", A_LO, 32'h0, 1'b0);
    rdx("dir", A_DIR, 32'h0, 1'b0);
    pins(8'h00, 8'h00, 8'h00, 8'h00);
    $display("test rereset done");
    summarize();
  end
endmodule
